//--- hdl/cpu_interrupt_priority_dispatch.sv
// interrupt priority encoder, dispatcher and priority registers
// assumes an axi4-lite master and a core that raises CORE_READY at boundaries
// Summary of operation
// - soft error interrupt uses level 1A, vector 54
// - hard error interrupt uses level 1D, vector 60
// - power fail pin low gives level 1E, vector 0C
// - after any expansion bus request, priority becomes 17
// - other interrupts set priority equal to their own level
// - bus request vector is device vector plus 200
// - at level 14 mass storage one uses 108, two uses 104
// - soft pending summary holds flags for levels 1 to 15
// - priority level register write loads the processor priority field
// - soft request register write posts request at the written level
// - cache parity and ecc errors report as soft errors
// - bad length, reserved command, timeouts, unacked data are soft errors
// - i/o read timeout or nonexistent memory errors are soft errors
// - taking an interrupt saves pc and status longword first
// - halt saves state and code, priority 1F, control to firmware
`timescale 1ns/10ps
`default_nettype none
module cpu_interrupt_priority_dispatch
  import irq_dispatch_pkg::*;
#(
  parameter int ADDR_W = 8,
  parameter int SOFT_W = 8,
  parameter int HARD_W = 4,
  parameter int BVEC_W = 9
) (
  input  wire logic              MCLK,
  input  wire logic              RST,
  input  wire logic [ADDR_W-1:0] AWADDR,
  input  wire logic              AWVALID,
  output logic                   AWREADY,
  input  wire logic [31:0]       WDATA,
  input  wire logic [3:0]        WSTRB,
  input  wire logic              WVALID,
  output logic                   WREADY,
  output logic [1:0]             BRESP,
  output logic                   BVALID,
  input  wire logic              BREADY,
  input  wire logic [ADDR_W-1:0] ARADDR,
  input  wire logic              ARVALID,
  output logic                   ARREADY,
  output logic [31:0]            RDATA,
  output logic [1:0]             RRESP,
  output logic                   RVALID,
  input  wire logic              RREADY,
  input  wire logic              POWER_FAIL_PIN_L,
  input  wire logic [HARD_W-1:0] HARD_ERR_SRC,
  input  wire logic [SOFT_W-1:0] SOFT_ERR_SRC,
  input  wire logic              INTERVAL_TIMER_REQ,
  input  wire logic              CONSOLE_RX_REQ,
  input  wire logic              CONSOLE_TX_REQ,
  input  wire logic              PROG_TIMER0_REQ,
  input  wire logic              PROG_TIMER1_REQ,
  input  wire logic              MASS_STORAGE1_REQ,
  input  wire logic              MASS_STORAGE2_REQ,
  input  wire logic              NETWORK_REQ,
  input  wire logic              DOORBELL_REQ,
  input  wire logic              BUS_REQUEST_LEVEL7_L,
  input  wire logic              BUS_REQUEST_LEVEL6_L,
  input  wire logic              BUS_REQUEST_LEVEL5_L,
  input  wire logic              BUS_REQUEST_LEVEL4_L,
  input  wire logic [BVEC_W-1:0] BUS_VECTOR,
  input  wire logic              HALT_REQ,
  input  wire logic [5:0]        HALT_CODE,
  input  wire logic              CORE_READY,
  input  wire logic [31:0]       CORE_PC,
  input  wire logic [31:0]       CORE_PSL,
  output logic                   DISPATCH_STB,
  output logic [VEC_W-1:0]       DISPATCH_VECTOR,
  output logic [LVL_W-1:0]       DISPATCH_LEVEL,
  output logic                   HALT_STB,
  output logic [5:0]             SAVED_HALT_CODE,
  output logic [31:0]            SAVED_PC,
  output logic [31:0]            SAVED_PSL,
  output logic [LVL_W-1:0]       PROCESSOR_PRIORITY,
  output logic                   IRQ
);
  typedef enum logic [2:0] {
    S_IDLE = 3'b001,
    S_DISP = 3'b010,
    S_HALT = 3'b100
  } state_t;

  // byte lanes merged into the old value; unwritten lanes are kept
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  state_t            st_q, st_d;
  logic [4:0]        ipl_q, ipl_d;
  logic [15:1]       sw_sum_q, sw_sum_d;
  logic              pf_q, pf_d, hard_q, hard_d, soft_q, soft_d;
  logic [EV_W-1:0]   ev_q, ev_d, mask_q, mask_d;
  logic              irq_q, irq_d;
  logic              dstb_q, dstb_d, hstb_q, hstb_d, dbus_q, dbus_d;
  logic [15:0]       dvec_q, dvec_d;
  logic [4:0]        dlvl_q, dlvl_d;
  logic [5:0]        hcode_q, hcode_d;
  logic [31:0]       spc_q, spc_d, spsl_q, spsl_d;
  logic [NSRC-1:0]   req;
  logic [4:0]        src, best_lvl, sw_lvl;
  logic [15:0]       best_vec;
  logic              take;
  logic [ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0]       wdata_q, wdata_d, rdata_q, rdata_d;
  logic [3:0]        wstrb_q, wstrb_d;
  logic              awh_q, awh_d, wh_q, wh_d, bvalid_q, bvalid_d, rvalid_q, rvalid_d;
  logic [1:0]        bresp_q, bresp_d, rresp_q, rresp_d;
  logic              wr_en;
  logic [7:0]        wr_idx;
  logic [31:0]       wr_data;

  // request vector in falling priority order; bus lines are active low
  always_comb begin
    sw_lvl = '0;
    for (int i = 1; i < 16; i++) begin
      if (sw_sum_q[i]) begin
        sw_lvl = 5'(i);
      end
    end
    req = {sw_lvl != '0, !BUS_REQUEST_LEVEL4_L, DOORBELL_REQ, NETWORK_REQ,
           MASS_STORAGE2_REQ, MASS_STORAGE1_REQ, PROG_TIMER1_REQ, PROG_TIMER0_REQ,
           CONSOLE_TX_REQ, CONSOLE_RX_REQ, !BUS_REQUEST_LEVEL5_L, !BUS_REQUEST_LEVEL6_L,
           INTERVAL_TIMER_REQ, !BUS_REQUEST_LEVEL7_L, soft_q, hard_q, pf_q};
    src = SRC_SW;
    for (int s = NSRC - 1; s >= 0; s--) begin
      if (req[s]) begin
        src = 5'(s);
      end
    end
    best_lvl = (src == SRC_SW) ? sw_lvl : SRC_LVL[src];
    best_vec = SRC_VEC[src];
    if (src == SRC_SW) begin
      best_vec = SW_VEC_BASE + {9'h000, sw_lvl, 2'b00};
    end else if (src == SRC_BR7 || src == SRC_BR6 || src == SRC_BR5 || src == SRC_BR4) begin
      best_vec = BUS_VEC_BASE + 16'(BUS_VECTOR);
    end
    take = (st_q == S_IDLE) && CORE_READY && !HALT_REQ && (best_lvl > ipl_q);
  end

  // axi4-lite slave: one write and one read at a time, a read answers one cycle later, a write two
  always_comb begin
    awh_d = awh_q;
    wh_d = wh_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = bvalid_q;
    bresp_d = bresp_q;
    rvalid_d = rvalid_q;
    rresp_d = rresp_q;
    rdata_d = rdata_q;
    wr_en = 1'b0;
    wr_idx = 8'(awaddr_q >> 2);
    wr_data = wdata_q;
    if (AWVALID && !awh_q) begin
      awh_d = 1'b1;
      awaddr_d = AWADDR;
    end
    if (WVALID && !wh_q) begin
      wh_d = 1'b1;
      wdata_d = WDATA;
      wstrb_d = WSTRB;
    end
    if (bvalid_q && BREADY) begin
      bvalid_d = 1'b0;
    end
    if (awh_q && wh_q && !bvalid_q) begin
      wr_en = 1'b1;
      awh_d = 1'b0;
      wh_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = RESP_OKAY;
      case (wr_idx)
        IDX_PRIORITY_LEVEL: wr_data = merge({11'h000, ipl_q, 16'h0000}, wdata_q, wstrb_q);
        IDX_SOFT_PENDING:   wr_data = merge({16'h0000, sw_sum_q, 1'b0}, wdata_q, wstrb_q);
        IDX_EVENT_MASK:     wr_data = merge({27'h0, mask_q}, wdata_q, wstrb_q);
        IDX_SOFT_REQUEST, IDX_EVENT_STATUS: wr_data = merge(32'h0, wdata_q, wstrb_q);
        IDX_LAST_DISPATCH:  wr_data = wdata_q;
        default:            bresp_d = RESP_DECERR;
      endcase
    end
    if (rvalid_q && RREADY) begin
      rvalid_d = 1'b0;
    end else if (ARVALID && !rvalid_q) begin
      rvalid_d = 1'b1;
      rresp_d = RESP_OKAY;
      case (8'(ARADDR >> 2))
        IDX_PRIORITY_LEVEL: rdata_d = {11'h000, ipl_q, 16'h0000};
        IDX_SOFT_REQUEST:   rdata_d = 32'h0; // write only
        IDX_SOFT_PENDING:   rdata_d = {16'h0000, sw_sum_q, 1'b0};
        IDX_EVENT_STATUS:   rdata_d = {27'h0, ev_q};
        IDX_EVENT_MASK:     rdata_d = {27'h0, mask_q};
        IDX_LAST_DISPATCH:  rdata_d = {11'h000, dlvl_q, dvec_q};
        default: begin
          rdata_d = 32'h0;
          rresp_d = RESP_DECERR;
        end
      endcase
    end
  end

  // dispatch and halt sequencing; a software write to the level wins
  always_comb begin
    st_d = st_q;
    ipl_d = ipl_q;
    sw_sum_d = sw_sum_q;
    pf_d = pf_q;
    hard_d = hard_q;
    soft_d = soft_q;
    dstb_d = 1'b0;
    hstb_d = 1'b0;
    dbus_d = dbus_q;
    dvec_d = dvec_q;
    dlvl_d = dlvl_q;
    hcode_d = hcode_q;
    spc_d = spc_q;
    spsl_d = spsl_q;
    ev_d = ev_q;
    mask_d = mask_q;
    case (st_q)
      S_IDLE: begin
        if (HALT_REQ && CORE_READY) begin
          st_d = S_HALT;
          ipl_d = LVL_HALT;
          hstb_d = 1'b1;
          hcode_d = HALT_CODE;
          spc_d = CORE_PC;
          spsl_d = CORE_PSL;
        end else if (take) begin
          st_d = S_DISP;
          spc_d = CORE_PC;
          spsl_d = CORE_PSL;
          dstb_d = 1'b1;
          dvec_d = best_vec;
          dlvl_d = best_lvl;
          dbus_d = (best_vec >= BUS_VEC_BASE) && (SRC_VEC[src] == '0) && (src != SRC_SW);
          ipl_d = dbus_d ? LVL_BUS_IPL : best_lvl;
          if (src == SRC_PWR) pf_d = 1'b0;
          if (src == SRC_HARD) hard_d = 1'b0;
          if (src == SRC_SOFT) soft_d = 1'b0;
          if (src == SRC_SW) sw_sum_d[sw_lvl[3:0]] = 1'b0;
        end
      end
      S_DISP: st_d = S_IDLE; // one quiet cycle lets the core see the strobe
      S_HALT: begin
        if (!HALT_REQ) begin
          st_d = S_IDLE; // firmware has taken over and dropped the request
        end
      end
      default: st_d = S_IDLE;
    endcase
    // sources set after clears so an event in the clearing cycle survives
    if (!POWER_FAIL_PIN_L) pf_d = 1'b1;
    if (|HARD_ERR_SRC) hard_d = 1'b1;
    if (|SOFT_ERR_SRC) soft_d = 1'b1;
    if (wr_en && wr_idx == IDX_PRIORITY_LEVEL) ipl_d = wr_data[20:16];
    if (wr_en && wr_idx == IDX_SOFT_PENDING) sw_sum_d = wr_data[15:1];
    if (wr_en && wr_idx == IDX_SOFT_REQUEST && wr_data[3:0] != '0) begin
      sw_sum_d[wr_data[3:0]] = 1'b1;
    end
    if (wr_en && wr_idx == IDX_EVENT_MASK) mask_d = wr_data[EV_W-1:0];
    if (wr_en && wr_idx == IDX_EVENT_STATUS) ev_d = ev_q & ~wr_data[EV_W-1:0];
    ev_d = ev_d | {!POWER_FAIL_PIN_L, |HARD_ERR_SRC, |SOFT_ERR_SRC, hstb_d, dstb_d};
    irq_d = |(ev_d & mask_d);
  end

  // state registers
  always_ff @(posedge MCLK) begin
    if (RST) begin
      st_q <= S_IDLE;
      ipl_q <= LVL_HALT; // comes out of reset blocking every maskable source
      sw_sum_q <= '0;
      {pf_q, hard_q, soft_q, dstb_q, hstb_q, dbus_q, irq_q} <= '0;
      {dvec_q, dlvl_q, hcode_q, spc_q, spsl_q, ev_q, mask_q} <= '0;
      {awh_q, wh_q, bvalid_q, rvalid_q, bresp_q, rresp_q} <= '0;
      {awaddr_q, wdata_q, wstrb_q, rdata_q} <= '0;
    end else begin
      st_q <= st_d;
      ipl_q <= ipl_d;
      sw_sum_q <= sw_sum_d;
      {pf_q, hard_q, soft_q, dstb_q, hstb_q, dbus_q, irq_q} <=
        {pf_d, hard_d, soft_d, dstb_d, hstb_d, dbus_d, irq_d};
      {dvec_q, dlvl_q, hcode_q, spc_q, spsl_q, ev_q, mask_q} <=
        {dvec_d, dlvl_d, hcode_d, spc_d, spsl_d, ev_d, mask_d};
      {awh_q, wh_q, bvalid_q, rvalid_q, bresp_q, rresp_q} <=
        {awh_d, wh_d, bvalid_d, rvalid_d, bresp_d, rresp_d};
      {awaddr_q, wdata_q, wstrb_q, rdata_q} <= {awaddr_d, wdata_d, wstrb_d, rdata_d};
    end
  end

  // outputs straight from flops
  assign AWREADY = !awh_q;
  assign WREADY = !wh_q;
  assign BVALID = bvalid_q;
  assign BRESP = bresp_q;
  assign ARREADY = !rvalid_q;
  assign RVALID = rvalid_q;
  assign RDATA = rdata_q;
  assign RRESP = rresp_q;
  assign DISPATCH_STB = dstb_q;
  assign DISPATCH_VECTOR = dvec_q;
  assign DISPATCH_LEVEL = dlvl_q;
  assign HALT_STB = hstb_q;
  assign SAVED_HALT_CODE = hcode_q;
  assign SAVED_PC = spc_q;
  assign SAVED_PSL = spsl_q;
  assign PROCESSOR_PRIORITY = ipl_q;
  assign IRQ = irq_q;

  // checks
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (RST);
  sequence s_take_mass1;
    take && src == SRC_MASS1;
  endsequence
  sequence s_sw_post;
    wr_en && wr_idx == IDX_SOFT_REQUEST && wr_data[3:0] != '0;
  endsequence
  a_soft_vector: assert property (DISPATCH_STB && DISPATCH_LEVEL == LVL_SOFT_ERR
    |-> DISPATCH_VECTOR == VEC_SOFT_ERR) else $error("soft error vector wrong");
  a_hard_vector: assert property (DISPATCH_STB && DISPATCH_LEVEL == LVL_HARD_ERR
    |-> DISPATCH_VECTOR == VEC_HARD_ERR) else $error("hard error vector wrong");
  a_pwr_dispatch: assert property (pf_q && ipl_q < LVL_PWR_FAIL && take
    |=> DISPATCH_STB && DISPATCH_VECTOR == VEC_PWR_FAIL) else $error("power fail lost");
  a_bus_priority: assert property (DISPATCH_STB && dbus_q
    |-> PROCESSOR_PRIORITY == LVL_BUS_IPL) else $error("bus priority not 17");
  a_other_priority: assert property (DISPATCH_STB && !dbus_q
    |-> PROCESSOR_PRIORITY == DISPATCH_LEVEL) else $error("priority not level");
  a_bus_offset: assert property (take && (src == SRC_BR7 || src == SRC_BR4)
    |=> DISPATCH_VECTOR == BUS_VEC_BASE + 16'($past(BUS_VECTOR))) else $error("bus vector");
  a_mass_vector: assert property (s_take_mass1 |=> DISPATCH_VECTOR == VEC_MASS1)
    else $error("mass storage vector wrong");
  a_sw_post: assert property (s_sw_post |=> sw_sum_q[$past(wr_data[3:0])])
    else $error("soft request not posted");
  a_ipl_load: assert property (wr_en && wr_idx == IDX_PRIORITY_LEVEL
    |=> PROCESSOR_PRIORITY == $past(wr_data[20:16])) else $error("level not loaded");
  a_soft_latch: assert property (|SOFT_ERR_SRC |=> soft_q) else $error("soft lost");
  a_save_pc: assert property (DISPATCH_STB |-> SAVED_PC == $past(CORE_PC))
    else $error("pc not saved");
  a_halt_ipl: assert property (HALT_STB |-> PROCESSOR_PRIORITY == LVL_HALT ##1 !HALT_STB)
    else $error("halt priority wrong");
  a_strict_above: assert property (DISPATCH_STB |-> DISPATCH_LEVEL > $past(PROCESSOR_PRIORITY))
    else $error("took request not above priority");
endmodule
`default_nettype wire

//--- hdl/irq_dispatch_pkg.sv
// constants for the interrupt priority and dispatch block
// assumes a 32-bit register bus; levels are 5-bit processor priorities
package irq_dispatch_pkg;
  localparam int LVL_W = 5;
  localparam int VEC_W = 16;
  localparam int NSRC  = 17;
  // priority levels
  localparam logic [4:0] LVL_PWR_FAIL = 5'h1e;
  localparam logic [4:0] LVL_HARD_ERR = 5'h1d;
  localparam logic [4:0] LVL_SOFT_ERR = 5'h1a;
  localparam logic [4:0] LVL_BUS_IPL  = 5'h17;
  localparam logic [4:0] LVL_HALT     = 5'h1f;
  // vector offsets into the system control block
  localparam logic [15:0] VEC_PWR_FAIL = 16'h000c;
  localparam logic [15:0] VEC_HARD_ERR = 16'h0060;
  localparam logic [15:0] VEC_SOFT_ERR = 16'h0054;
  localparam logic [15:0] VEC_MASS1    = 16'h0108;
  localparam logic [15:0] VEC_MASS2    = 16'h0104;
  localparam logic [15:0] BUS_VEC_BASE = 16'h0200;
  localparam logic [15:0] SW_VEC_BASE  = 16'h0080;
  // sources in falling priority order; the table gives level and vector
  localparam logic [4:0] SRC_PWR = 5'h00;
  localparam logic [4:0] SRC_HARD = 5'h01;
  localparam logic [4:0] SRC_SOFT = 5'h02;
  localparam logic [4:0] SRC_BR7 = 5'h03;
  localparam logic [4:0] SRC_BR6 = 5'h05;
  localparam logic [4:0] SRC_BR5 = 5'h06;
  localparam logic [4:0] SRC_MASS1 = 5'h0b;
  localparam logic [4:0] SRC_BR4 = 5'h0f;
  localparam logic [4:0] SRC_SW = 5'h10;
  localparam logic [4:0] SRC_LVL [NSRC] = '{5'h1e, 5'h1d, 5'h1a, 5'h17, 5'h16, 5'h16,
    5'h15, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14, 5'h00};
  localparam logic [15:0] SRC_VEC [NSRC] = '{16'h000c, 16'h0060, 16'h0054, 16'h0000,
    16'h00c0, 16'h0000, 16'h0000, 16'h00f8, 16'h00fc, 16'h0078, 16'h007c, 16'h0108,
    16'h0104, 16'h010c, 16'h0204, 16'h0000, 16'h0000};
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_PRIORITY_LEVEL = 8'h12;
  localparam logic [7:0] IDX_SOFT_REQUEST   = 8'h14;
  localparam logic [7:0] IDX_SOFT_PENDING   = 8'h15;
  localparam logic [7:0] IDX_EVENT_STATUS   = 8'h20;
  localparam logic [7:0] IDX_EVENT_MASK     = 8'h21;
  localparam logic [7:0] IDX_LAST_DISPATCH  = 8'h22;
  // event status bits
  localparam int EV_W = 5;
  localparam int EV_DISPATCH = 0;
  localparam int EV_HALT     = 1;
  localparam int EV_SOFT     = 2;
  localparam int EV_HARD     = 3;
  localparam int EV_PWR      = 4;
  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_DECERR = 2'h3;
endpackage

//--- verif/core_model.sv
// stand-in for the processor core: boundary flag, moving pc and status word
// assumes one clock with a synchronous active-high reset
`timescale 1ns/10ps
`default_nettype none
module core_model (
  input  wire logic        mclk,
  input  wire logic        rst,
  input  wire logic        slow,
  output logic             core_ready,
  output logic [31:0]      core_pc,
  output logic [31:0]      core_psl
);
  logic [31:0] pc_d;
  // slow mode reaches a boundary one cycle in four, so takes must wait
  assign core_ready = slow ? (core_pc[3:2] == 2'h0) : 1'b1;
  assign core_psl   = ~core_pc;
  assign pc_d       = core_pc + 32'h4;
  // pc moves every cycle, so a stale or late save shows up
  always_ff @(posedge mclk) begin
    if (rst) core_pc <= 32'h0;
    else core_pc <= pc_d;
  end
endmodule
`default_nettype wire

//--- verif/cpu_interrupt_priority_dispatch_tb.sv
// self-checking bench for the interrupt priority and dispatch block
// assumes the design package, the design and the core stand-in compile first
`timescale 1ns/10ps
`default_nettype none
module cpu_interrupt_priority_dispatch_tb;
  import irq_dispatch_pkg::*;
  logic        MCLK, RST, AWVALID, AWREADY, WVALID, WREADY, BVALID, BREADY, ARVALID, ARREADY;
  logic        RVALID, RREADY, POWER_FAIL_PIN_L, INTERVAL_TIMER_REQ, CONSOLE_RX_REQ;
  logic        CONSOLE_TX_REQ, PROG_TIMER0_REQ, PROG_TIMER1_REQ, MASS_STORAGE1_REQ;
  logic        MASS_STORAGE2_REQ, NETWORK_REQ, DOORBELL_REQ, BUS_REQUEST_LEVEL7_L;
  logic        BUS_REQUEST_LEVEL6_L, BUS_REQUEST_LEVEL5_L, BUS_REQUEST_LEVEL4_L, HALT_REQ;
  logic        CORE_READY, DISPATCH_STB, HALT_STB, IRQ, slow, seen, irq_a;
  logic [7:0]  AWADDR, ARADDR, SOFT_ERR_SRC;
  logic [31:0] WDATA, RDATA, CORE_PC, CORE_PSL, SAVED_PC, SAVED_PSL, rd;
  logic [31:0] seed = 32'ha239;
  logic [3:0]  WSTRB, HARD_ERR_SRC, w;
  logic [1:0]  BRESP, RRESP, rr, br;
  logic [8:0]  BUS_VECTOR;
  logic [5:0]  HALT_CODE, SAVED_HALT_CODE;
  logic [15:0] DISPATCH_VECTOR;
  logic [4:0]  DISPATCH_LEVEL, PROCESSOR_PRIORITY, p;
  int          bad_count = 0;
  int          num_checks = 0;
  // expected level and vector per source, bus entries get their vector at run time
  localparam logic [4:0]  LV [16] = '{5'h1e, 5'h1d, 5'h1a, 5'h17, 5'h16, 5'h16, 5'h15, 5'h14,
    5'h14, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14, 5'h14};
  localparam logic [15:0] VC [16] = '{16'h000c, 16'h0060, 16'h0054, 16'h0000, 16'h00c0,
    16'h0000, 16'h0000, 16'h00f8, 16'h00fc, 16'h0078, 16'h007c, 16'h0108, 16'h0104,
    16'h010c, 16'h0204, 16'h0000};

  cpu_interrupt_priority_dispatch u_cpu_interrupt_priority_dispatch (
    .MCLK(MCLK), .RST(RST), .AWADDR(AWADDR), .AWVALID(AWVALID), .AWREADY(AWREADY),
    .WDATA(WDATA), .WSTRB(WSTRB), .WVALID(WVALID), .WREADY(WREADY), .BRESP(BRESP),
    .BVALID(BVALID), .BREADY(BREADY), .ARADDR(ARADDR), .ARVALID(ARVALID), .ARREADY(ARREADY),
    .RDATA(RDATA), .RRESP(RRESP), .RVALID(RVALID), .RREADY(RREADY),
    .POWER_FAIL_PIN_L(POWER_FAIL_PIN_L), .HARD_ERR_SRC(HARD_ERR_SRC),
    .SOFT_ERR_SRC(SOFT_ERR_SRC), .INTERVAL_TIMER_REQ(INTERVAL_TIMER_REQ),
    .CONSOLE_RX_REQ(CONSOLE_RX_REQ), .CONSOLE_TX_REQ(CONSOLE_TX_REQ),
    .PROG_TIMER0_REQ(PROG_TIMER0_REQ), .PROG_TIMER1_REQ(PROG_TIMER1_REQ),
    .MASS_STORAGE1_REQ(MASS_STORAGE1_REQ), .MASS_STORAGE2_REQ(MASS_STORAGE2_REQ),
    .NETWORK_REQ(NETWORK_REQ), .DOORBELL_REQ(DOORBELL_REQ),
    .BUS_REQUEST_LEVEL7_L(BUS_REQUEST_LEVEL7_L), .BUS_REQUEST_LEVEL6_L(BUS_REQUEST_LEVEL6_L),
    .BUS_REQUEST_LEVEL5_L(BUS_REQUEST_LEVEL5_L), .BUS_REQUEST_LEVEL4_L(BUS_REQUEST_LEVEL4_L),
    .BUS_VECTOR(BUS_VECTOR), .HALT_REQ(HALT_REQ), .HALT_CODE(HALT_CODE),
    .CORE_READY(CORE_READY), .CORE_PC(CORE_PC), .CORE_PSL(CORE_PSL),
    .DISPATCH_STB(DISPATCH_STB), .DISPATCH_VECTOR(DISPATCH_VECTOR),
    .DISPATCH_LEVEL(DISPATCH_LEVEL), .HALT_STB(HALT_STB), .SAVED_HALT_CODE(SAVED_HALT_CODE),
    .SAVED_PC(SAVED_PC), .SAVED_PSL(SAVED_PSL), .PROCESSOR_PRIORITY(PROCESSOR_PRIORITY),
    .IRQ(IRQ));

  core_model u_core_model (.mclk(MCLK), .rst(RST), .slow(slow), .core_ready(CORE_READY),
    .core_pc(CORE_PC), .core_psl(CORE_PSL));

  // free-running 50 MHz clock
  initial begin
    MCLK = 1'b0;
    forever #10 MCLK = ~MCLK;
  end

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // ready is looked at mid-cycle, where it is settled; transfers land on the next edge
  task automatic axi_wr(input logic [7:0] idx, input logic [31:0] d);
    logic ta, tw, tb;
    int   n;
    n = 0;
    tb = 1'b0;
    @(posedge MCLK);
    AWADDR <= {idx[5:0], 2'h0};
    WDATA <= d;
    AWVALID <= 1'b1;
    WVALID <= 1'b1;
    BREADY <= 1'b1;
    while (!tb && n < 100) begin
      @(negedge MCLK);
      ta = AWVALID && AWREADY;
      tw = WVALID && WREADY;
      tb = (BVALID === 1'b1);
      if (tb) br = BRESP;
      @(posedge MCLK);
      if (ta) AWVALID <= 1'b0;
      if (tw) WVALID <= 1'b0;
      n++;
    end
    BREADY <= 1'b0;
    if (!tb) bad_count++;
  endtask

  task automatic axi_rd(input logic [7:0] idx, output logic [31:0] d, output logic [1:0] r);
    logic ta, tr;
    int   n;
    n = 0;
    tr = 1'b0;
    @(posedge MCLK);
    ARADDR <= {idx[5:0], 2'h0};
    ARVALID <= 1'b1;
    RREADY <= 1'b1;
    while (!tr && n < 100) begin
      @(negedge MCLK);
      ta = ARVALID && ARREADY;
      tr = (RVALID === 1'b1);
      d = RDATA;
      r = RRESP;
      @(posedge MCLK);
      if (ta) ARVALID <= 1'b0;
      n++;
    end
    RREADY <= 1'b0;
    if (!tr) bad_count++;
  endtask

  // bounded wait for either strobe; a hang shows as seen low
  task automatic wait_stb(output logic s);
    s = 1'b0;
    for (int i = 0; i < 60 && !s; i++) begin
      @(posedge MCLK);
      #1;
      s = (DISPATCH_STB === 1'b1) || (HALT_STB === 1'b1);
    end
  endtask

  task automatic set_src(input int k, input logic on);
    case (k)
      0: POWER_FAIL_PIN_L <= !on;
      1: HARD_ERR_SRC <= on ? 4'h1 << (xs() % 4) : 4'h0;
      2: SOFT_ERR_SRC <= on ? 8'h1 << (xs() % 8) : 8'h0;
      3: BUS_REQUEST_LEVEL7_L <= !on;
      4: INTERVAL_TIMER_REQ <= on;
      5: BUS_REQUEST_LEVEL6_L <= !on;
      6: BUS_REQUEST_LEVEL5_L <= !on;
      7: CONSOLE_RX_REQ <= on;
      8: CONSOLE_TX_REQ <= on;
      9: PROG_TIMER0_REQ <= on;
      10: PROG_TIMER1_REQ <= on;
      11: MASS_STORAGE1_REQ <= on;
      12: MASS_STORAGE2_REQ <= on;
      13: NETWORK_REQ <= on;
      14: DOORBELL_REQ <= on;
      default: BUS_REQUEST_LEVEL4_L <= !on;
    endcase
  endtask

  // one source alone from priority zero; latched sources are pulsed a single cycle
  task automatic svc(input int k);
    logic        bus;
    logic [15:0] ev;
    bus = (k == 3) || (k == 5) || (k == 6) || (k == 15);
    axi_wr(IDX_PRIORITY_LEVEL, 32'h0);
    BUS_VECTOR <= 9'(xs()) & 9'h1fc;
    set_src(k, 1'b1);
    if (k < 3) begin
      @(posedge MCLK);
      set_src(k, 1'b0);
    end
    wait_stb(seen);
    ev = bus ? 16'h0200 + {7'h0, BUS_VECTOR} : VC[k];
    chk(DISPATCH_STB, 1'b1);
    chk(DISPATCH_VECTOR, ev);
    chk(DISPATCH_LEVEL, LV[k]);
    chk(PROCESSOR_PRIORITY, bus ? 5'h17 : LV[k]);
    chk(SAVED_PC, CORE_PC - 32'h4);
    chk(SAVED_PSL, ~(CORE_PC - 32'h4));
    @(posedge MCLK);
    set_src(k, 1'b0);
  endtask

  // hang guard, sized well above the whole sequence
  initial begin
    repeat (30000) @(posedge MCLK);
    bad_count++;
    give_verdict();
  end

  // main sequence
  initial begin
    {AWVALID, WVALID, BREADY, ARVALID, RREADY, HALT_REQ, slow, INTERVAL_TIMER_REQ} = '0;
    {CONSOLE_RX_REQ, CONSOLE_TX_REQ, PROG_TIMER0_REQ, PROG_TIMER1_REQ} = '0;
    {MASS_STORAGE1_REQ, MASS_STORAGE2_REQ, NETWORK_REQ, DOORBELL_REQ} = '0;
    {POWER_FAIL_PIN_L, BUS_REQUEST_LEVEL7_L, BUS_REQUEST_LEVEL6_L} = '1;
    {BUS_REQUEST_LEVEL5_L, BUS_REQUEST_LEVEL4_L} = '1;
    {AWADDR, ARADDR, SOFT_ERR_SRC, WDATA, HARD_ERR_SRC, BUS_VECTOR, HALT_CODE} = '0;
    WSTRB = 4'hf;
    RST = 1'b1;
    repeat (16) @(posedge MCLK);
    RST <= 1'b0;
    @(posedge MCLK);
    #1;
    chk(PROCESSOR_PRIORITY, 5'h1f);
    axi_rd(IDX_PRIORITY_LEVEL, rd, rr);
    chk(rd[20:16], 5'h1f);
    p = 5'(xs());
    axi_wr(IDX_PRIORITY_LEVEL, {11'h0, p, 16'h0});
    axi_rd(IDX_PRIORITY_LEVEL, rd, rr);
    chk(rd, {11'h0, p, 16'h0});
    chk(PROCESSOR_PRIORITY, p);
    // every source but the software request, once with a prompt core and once with a slow one
    for (int m = 0; m < 2; m++) begin
      slow <= m[0];
      for (int k = 0; k < 16; k++) svc(k);
    end
    // a request at the current priority is held, one above it is taken
    axi_wr(IDX_PRIORITY_LEVEL, {11'h0, 5'h14, 16'h0});
    MASS_STORAGE1_REQ <= 1'b1;
    wait_stb(seen);
    chk(seen, 1'b0);
    axi_wr(IDX_PRIORITY_LEVEL, {11'h0, 5'h13, 16'h0});
    wait_stb(seen);
    chk(DISPATCH_VECTOR, 16'h0108);
    @(posedge MCLK);
    MASS_STORAGE1_REQ <= 1'b0;
    // hard and soft together: hard first, soft held until priority drops
    axi_wr(IDX_PRIORITY_LEVEL, 32'h0);
    HARD_ERR_SRC <= 4'h8;
    SOFT_ERR_SRC <= 8'h80;
    @(posedge MCLK);
    {HARD_ERR_SRC, SOFT_ERR_SRC} <= '0;
    wait_stb(seen);
    chk(DISPATCH_LEVEL, 5'h1d);
    wait_stb(seen);
    chk(seen, 1'b0);
    axi_wr(IDX_PRIORITY_LEVEL, 32'h0);
    wait_stb(seen);
    chk(DISPATCH_VECTOR, 16'h0054);
    // event status, mask and interrupt line; masking must change the line
    axi_rd(IDX_EVENT_STATUS, rd, rr);
    chk(rd[EV_DISPATCH], 1'b1);
    axi_wr(IDX_EVENT_MASK, 32'h0);
    repeat (2) @(posedge MCLK);
    irq_a = IRQ;
    axi_wr(IDX_EVENT_MASK, 32'h1f);
    repeat (2) @(posedge MCLK);
    chk(irq_a ^ IRQ, 1'b1);
    axi_wr(IDX_EVENT_STATUS, 32'h1f);
    axi_rd(IDX_EVENT_STATUS, rd, rr);
    chk(rd[4:0], 5'h0);
    chk(IRQ, 1'b0);
    chk(br, RESP_OKAY);
    axi_rd(8'h30, rd, rr);
    chk(rr, RESP_DECERR);
    // unmapped write is refused with a decode error
    axi_wr(8'h30, 32'h0);
    chk(br, RESP_DECERR);
    // software request: posted, summarised, then dispatched at its level
    axi_wr(IDX_PRIORITY_LEVEL, {11'h0, 5'h1f, 16'h0});
    w = 4'(xs() % 15 + 1);
    axi_wr(IDX_SOFT_REQUEST, {28'h0, w});
    axi_wr(IDX_SOFT_REQUEST, 32'h0);
    axi_rd(IDX_SOFT_PENDING, rd, rr);
    chk(rd, 32'h1 << w);
    axi_rd(IDX_SOFT_REQUEST, rd, rr);
    chk(rd, 32'h0);
    axi_wr(IDX_PRIORITY_LEVEL, 32'h0);
    wait_stb(seen);
    chk(DISPATCH_VECTOR, 16'h0080 + {10'h0, w, 2'h0});
    chk(PROCESSOR_PRIORITY, {1'b0, w});
    axi_rd(IDX_SOFT_PENDING, rd, rr);
    chk(rd, 32'h0);
    // halt from any priority, code and state saved
    HALT_CODE <= 6'(xs());
    HALT_REQ <= 1'b1;
    wait_stb(seen);
    chk(HALT_STB, 1'b1);
    chk(SAVED_HALT_CODE, HALT_CODE);
    chk(PROCESSOR_PRIORITY, 5'h1f);
    chk(SAVED_PC, CORE_PC - 32'h4);
    @(posedge MCLK);
    HALT_REQ <= 1'b0;
    repeat (4) @(posedge MCLK);
    give_verdict();
  end
endmodule
`default_nettype wire
